// [rtl/standby_clock_gating_pkg.sv]
package standby_clock_gating_pkg;

   // number of peripherals with module sleep control
   localparam int unsigned NUM_PERIPH = 8;

   // key value that unlocks protected writes until the next key write
   localparam logic [31:0] UNLOCK_KEY = 32'ha5a5a501;

   // mask control sits in bit 0 of each stop-mask register
   localparam int unsigned MASK_BIT_POS = 0;

   // reset values
   localparam logic SRC_MASK_RST = 1'b0;
   localparam logic SLEEP_BIT_RST = 1'b1;
   localparam logic PERIPH_MASK_RST = 1'b0;

   // chip modes
   typedef enum logic [2:0]
   {
      MODE_RUN = 3'h0,
      MODE_STOP = 3'h1,
      MODE_DEEPEST_HALT = 3'h2,
      MODE_PERIODIC_WAKE_RUN = 3'h3,
      MODE_PERIODIC_HALT = 3'h4
   } chip_mode_type;

   // software write request to the protected registers
   typedef struct packed
   {
      logic key_wr;
      logic [31:0] key_data;
      logic src_wr;
      logic [2:0] src_sel;
      logic [31:0] src_data;
      logic periph_wr;
      logic [NUM_PERIPH-1:0] periph_sel;
      logic sleep_bit;
      logic halt_mask;
   } sw_write_type;

   // source enables
   typedef struct packed
   {
      logic lsio;
      logic hsio;
      logic mosc;
      logic hvio;
      logic pll;
      logic cpu;
      logic sbus;
      logic hbus;
   } src_en_type;

   // source select codes for the oscillator and pll masks
   localparam logic [2:0] SRC_SEL_HSIO = 3'h0;
   localparam logic [2:0] SRC_SEL_MOSC = 3'h1;
   localparam logic [2:0] SRC_SEL_PLL = 3'h2;

endpackage

// [rtl/glitch_free_gate.sv]
`timescale 1ns/10ps
module glitch_free_gate
(
   // gated clock and its enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   // output
   output logic gclk_o
);

   logic en_meta_q;
   logic en_meta_d;
   logic en_sync_q;
   logic en_sync_d;
   logic en_latch;

   // only the second stage may be read by gating logic
   always_comb
   begin
      en_meta_d = en_i;
      en_sync_d = en_meta_q;
   end

   // enable crosses into the clock's own domain first
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         en_meta_q <= 1'b0;
         en_sync_q <= 1'b0;
      end
      else
      begin
         en_meta_q <= en_meta_d;
         en_sync_q <= en_sync_d;
      end
   end

   // latch passes only while clock low, so no truncated pulses
   always_latch
   begin
      if (!clk_i)
         en_latch <= en_sync_q;
   end

   assign gclk_o = clk_i & en_latch;

endmodule

// [rtl/standby_clock_gating.sv]
`timescale 1ns/10ps
module standby_clock_gating
   import standby_clock_gating_pkg::*;
(
   // system
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // raw source clocks
   input wire logic low_speed_internal_osc_clk_i,
   input wire logic high_speed_internal_osc_clk_i,
   input wire logic main_osc_clk_i,
   input wire logic high_voltage_internal_osc_clk_i,
   input wire logic pll_output_clk_i,
   input wire logic cpu_clk_i,
   input wire logic system_bus_clk_i,
   input wire logic high_bus_clk_i,
   input wire logic [NUM_PERIPH-1:0] periph_clk_i,
   // control
   input wire chip_mode_type chip_mode_i,
   input wire logic voltage_monitor_deep_ctrl_i,
   input wire logic [NUM_PERIPH-1:0] module_rst_i,
   input wire logic chip_standby_release_i,
   input wire sw_write_type sw_wr_i,
   input wire logic clock_key_wr_i,
   input wire logic [31:0] clock_key_data_i,
   // gated clocks
   output logic low_speed_internal_osc_clk_o,
   output logic high_speed_internal_osc_clk_o,
   output logic main_osc_clk_o,
   output logic high_voltage_internal_osc_clk_o,
   output logic pll_output_clk_o,
   output logic cpu_clk_o,
   output logic system_bus_clk_o,
   output logic high_bus_clk_o,
   output logic [NUM_PERIPH-1:0] periph_clk_o,
   // status
   output logic [2:0] source_halt_mask_o,
   output logic [NUM_PERIPH-1:0] module_sleep_bit_o,
   output logic [NUM_PERIPH-1:0] periph_halt_mask_o,
   output logic [NUM_PERIPH-1:0] periph_access_ok_o,
   output logic [NUM_PERIPH-1:0] periph_rst_o,
   output src_en_type src_en_o
);

   ////////////////////////////////////////////////////////////////////////
   // key protection and registers

   logic clk_key_q;
   logic clk_key_d;
   logic sleep_key_q;
   logic sleep_key_d;
   logic hsio_mask_q;
   logic hsio_mask_d;
   logic mosc_mask_q;
   logic mosc_mask_d;
   logic pll_mask_q;
   logic pll_mask_d;
   logic [NUM_PERIPH-1:0] sleep_q;
   logic [NUM_PERIPH-1:0] sleep_d;
   logic [NUM_PERIPH-1:0] pmask_q;
   logic [NUM_PERIPH-1:0] pmask_d;

   always_comb
   begin
      clk_key_d = clk_key_q;
      sleep_key_d = sleep_key_q;
      hsio_mask_d = hsio_mask_q;
      mosc_mask_d = mosc_mask_q;
      pll_mask_d = pll_mask_q;
      sleep_d = sleep_q;
      pmask_d = pmask_q;
      if (clock_key_wr_i)
         clk_key_d = (clock_key_data_i == UNLOCK_KEY);
      if (sw_wr_i.key_wr)
         sleep_key_d = (sw_wr_i.key_data == UNLOCK_KEY);
      // blocked unless clock key unlocked
      if (sw_wr_i.src_wr && clk_key_q)
      begin
         unique case (sw_wr_i.src_sel)
            SRC_SEL_HSIO: hsio_mask_d = sw_wr_i.src_data[MASK_BIT_POS];
            SRC_SEL_MOSC: mosc_mask_d = sw_wr_i.src_data[MASK_BIT_POS];
            SRC_SEL_PLL: pll_mask_d = sw_wr_i.src_data[MASK_BIT_POS];
            default: ;
         endcase
      end
      if (sw_wr_i.periph_wr && sleep_key_q)
      begin
         for (int i = 0; i < NUM_PERIPH; i++)
         begin
            if (sw_wr_i.periph_sel[i])
            begin
               sleep_d[i] = sw_wr_i.sleep_bit;
               pmask_d[i] = sw_wr_i.halt_mask;
            end
         end
      end
      // module reset wins over a same-cycle write
      for (int i = 0; i < NUM_PERIPH; i++)
      begin
         if (module_rst_i[i])
         begin
            sleep_d[i] = SLEEP_BIT_RST;
            pmask_d[i] = PERIPH_MASK_RST;
         end
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         clk_key_q <= 1'b0;
         sleep_key_q <= 1'b0;
         hsio_mask_q <= SRC_MASK_RST;
         mosc_mask_q <= SRC_MASK_RST;
         pll_mask_q <= SRC_MASK_RST;
         sleep_q <= {NUM_PERIPH{SLEEP_BIT_RST}};
         pmask_q <= {NUM_PERIPH{PERIPH_MASK_RST}};
      end
      else
      begin
         clk_key_q <= clk_key_d;
         sleep_key_q <= sleep_key_d;
         hsio_mask_q <= hsio_mask_d;
         mosc_mask_q <= mosc_mask_d;
         pll_mask_q <= pll_mask_d;
         sleep_q <= sleep_d;
         pmask_q <= pmask_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // enable decode

   logic halt_any;
   logic deepest;
   logic stop_or_phalt;
   src_en_type en_d;
   src_en_type en_q;
   logic [NUM_PERIPH-1:0] pen_d;
   logic [NUM_PERIPH-1:0] pen_q;

   always_comb
   begin
      halt_any = (chip_mode_i == MODE_STOP) || (chip_mode_i == MODE_DEEPEST_HALT) ||
                 (chip_mode_i == MODE_PERIODIC_HALT);
      deepest = (chip_mode_i == MODE_DEEPEST_HALT);
      stop_or_phalt = (chip_mode_i == MODE_STOP) || (chip_mode_i == MODE_PERIODIC_HALT);
      en_d.lsio = 1'b1;
      en_d.hsio = !halt_any || hsio_mask_q;
      en_d.mosc = !halt_any || mosc_mask_q;
      // deepest halt follows the voltage monitor control
      en_d.hvio = deepest ? voltage_monitor_deep_ctrl_i : 1'b1;
      // periodic wake run keeps pll stopped; deepest cuts the switchable area
      if (deepest)
         en_d.pll = 1'b0;
      else if (stop_or_phalt)
         en_d.pll = pll_mask_q;
      else
         en_d.pll = (chip_mode_i == MODE_RUN);
      en_d.cpu = !halt_any;
      en_d.sbus = !halt_any;
      en_d.hbus = !halt_any;
      // peripherals lose their clock in every halt mode unless their halt mask is set, and always while sleeping
      for (int i = 0; i < NUM_PERIPH; i++)
         pen_d[i] = !sleep_q[i] && (!halt_any || pmask_q[i]);
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         en_q <= '0;
         pen_q <= '0;
      end
      else
      begin
         en_q <= en_d;
         pen_q <= pen_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // glitch-free gates

   logic [7:0] src_clk;
   logic [7:0] src_en;
   logic [7:0] src_gclk;

   assign src_clk = {low_speed_internal_osc_clk_i, high_speed_internal_osc_clk_i, main_osc_clk_i,
                     high_voltage_internal_osc_clk_i, pll_output_clk_i, cpu_clk_i,
                     system_bus_clk_i, high_bus_clk_i};
   assign src_en = en_q;

   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_src
         glitch_free_gate u_gate
         (
            .clk_i(src_clk[g]),
            .rst_i(srst_i),
            .en_i(src_en[g]),
            .gclk_o(src_gclk[g])
         );
      end
      for (g = 0; g < NUM_PERIPH; g++)
      begin : g_periph
         // enable returns on wake, so a running clock restarts by itself
         glitch_free_gate u_gate
         (
            .clk_i(periph_clk_i[g]),
            .rst_i(srst_i),
            .en_i(pen_q[g]),
            .gclk_o(periph_clk_o[g])
         );
      end
   endgenerate

   assign {low_speed_internal_osc_clk_o, high_speed_internal_osc_clk_o, main_osc_clk_o,
           high_voltage_internal_osc_clk_o, pll_output_clk_o, cpu_clk_o,
           system_bus_clk_o, high_bus_clk_o} = src_gclk;

   ////////////////////////////////////////////////////////////////////////
   // status and access

   always_comb
   begin
      source_halt_mask_o = {pll_mask_q, mosc_mask_q, hsio_mask_q};
      module_sleep_bit_o = sleep_q;
      periph_halt_mask_o = pmask_q;
      src_en_o = en_q;
      periph_access_ok_o = ~sleep_q;
      // sleeping modules are not reset on standby release
      periph_rst_o = {NUM_PERIPH{chip_standby_release_i}} & ~sleep_q;
   end

endmodule

// [verification/standby_clock_gating_assertions.sv]
`timescale 1ns/10ps
module standby_clock_gating_checker
   import standby_clock_gating_pkg::*;
(
   // watched ports
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire chip_mode_type chip_mode_i,
   input wire logic voltage_monitor_deep_ctrl_i,
   input wire logic [NUM_PERIPH-1:0] module_rst_i,
   input wire logic chip_standby_release_i,
   input wire sw_write_type sw_wr_i,
   input wire logic [2:0] source_halt_mask_o,
   input wire logic [NUM_PERIPH-1:0] module_sleep_bit_o,
   input wire logic [NUM_PERIPH-1:0] periph_access_ok_o,
   input wire logic [NUM_PERIPH-1:0] periph_rst_o,
   input wire src_en_type src_en_o
);
default clocking @(posedge sys_clk_i); endclocking
default disable iff (srst_i);
logic halt;
logic deep;
assign deep = (chip_mode_i == MODE_DEEPEST_HALT);
assign halt = deep | (chip_mode_i inside {MODE_STOP, MODE_PERIODIC_HALT});
////////////////////////////////////////////////////////////////////////
property p_lsio; !srst_i |=> src_en_o.lsio; endproperty
a_lsio: assert property (p_lsio) else $error("lsio enable dropped");
property p_cpu_halt; halt |=> !(src_en_o.cpu | src_en_o.sbus | src_en_o.hbus); endproperty
a_cpu_halt: assert property (p_cpu_halt) else $error("cpu or bus on in halt");
property p_cpu_run;
   !srst_i && !halt |=> src_en_o.cpu && src_en_o.sbus && src_en_o.hbus;
endproperty
a_cpu_run: assert property (p_cpu_run) else $error("cpu or bus off in run");
property p_hsio; halt && !source_halt_mask_o[0] && !sw_wr_i.src_wr |=> !src_en_o.hsio; endproperty
a_hsio: assert property (p_hsio) else $error("hsio kept without mask");
property p_pll_deep; deep |=> !src_en_o.pll; endproperty
a_pll_deep: assert property (p_pll_deep) else $error("pll on in deepest halt");
property p_hvio;
   !srst_i |=> src_en_o.hvio == (!$past(deep) | $past(voltage_monitor_deep_ctrl_i));
endproperty
a_hvio: assert property (p_hvio) else $error("hvio enable wrong");
property p_access; 1'b1 |-> periph_access_ok_o == ~module_sleep_bit_o; endproperty
a_access: assert property (p_access) else $error("access flag wrong");
property p_mrst; module_rst_i[0] |=> module_sleep_bit_o[0]; endproperty
a_mrst: assert property (p_mrst) else $error("sleep bit not restored");
property p_prst;
   1'b1 |-> periph_rst_o == ({NUM_PERIPH{chip_standby_release_i}} & ~module_sleep_bit_o);
endproperty
a_prst: assert property (p_prst) else $error("release reset wrong");
endmodule
bind standby_clock_gating standby_clock_gating_checker chk_u
(
   .sys_clk_i(sys_clk_i), .srst_i(srst_i), .chip_mode_i(chip_mode_i),
   .voltage_monitor_deep_ctrl_i(voltage_monitor_deep_ctrl_i), .module_rst_i(module_rst_i),
   .chip_standby_release_i(chip_standby_release_i), .sw_wr_i(sw_wr_i),
   .source_halt_mask_o(source_halt_mask_o), .module_sleep_bit_o(module_sleep_bit_o),
   .periph_access_ok_o(periph_access_ok_o), .periph_rst_o(periph_rst_o), .src_en_o(src_en_o)
);

// [verification/standby_clock_gating_bench.sv]
`timescale 1ns/10ps
module standby_clock_gating_bench
   import standby_clock_gating_pkg::*;
;
logic sys_clk_i = 1'b0, srst_i = 1'b1, fclk = 1'b0, vmon = 1'b0, rel = 1'b0, ckw = 1'b0;
logic [31:0] ckd = 32'h0;
logic [NUM_PERIPH-1:0] mrst = '0, pclk_o, sleep_o, pmask_o, acc_o, prst_o;
chip_mode_type mode = MODE_RUN;
sw_write_type sw = '0;
src_en_type en_o;
logic [2:0] smask_o;
logic [7:0] gsrc_o;
logic [NUM_PERIPH+7:0] seen = '0;
// source mask sets written in turn, {pll, mosc, hsio}
logic [2:0] kv [2] = '{3'h5, 3'h2};
int miscompares = 0, n_checks = 0;
////////////////////////////////////////////////////////////////////////
// every raw source shares one fast clock so all gates get exercised
standby_clock_gating dut_u
(
   .sys_clk_i(sys_clk_i), .srst_i(srst_i), .low_speed_internal_osc_clk_i(fclk),
   .high_speed_internal_osc_clk_i(fclk), .main_osc_clk_i(fclk),
   .high_voltage_internal_osc_clk_i(fclk), .pll_output_clk_i(fclk), .cpu_clk_i(fclk),
   .system_bus_clk_i(fclk), .high_bus_clk_i(fclk), .periph_clk_i({NUM_PERIPH{fclk}}),
   .chip_mode_i(mode), .voltage_monitor_deep_ctrl_i(vmon), .module_rst_i(mrst),
   .chip_standby_release_i(rel), .sw_wr_i(sw), .clock_key_wr_i(ckw), .clock_key_data_i(ckd),
   .low_speed_internal_osc_clk_o(gsrc_o[7]), .high_speed_internal_osc_clk_o(gsrc_o[6]),
   .main_osc_clk_o(gsrc_o[5]), .high_voltage_internal_osc_clk_o(gsrc_o[4]),
   .pll_output_clk_o(gsrc_o[3]), .cpu_clk_o(gsrc_o[2]), .system_bus_clk_o(gsrc_o[1]),
   .high_bus_clk_o(gsrc_o[0]), .periph_clk_o(pclk_o),
   .source_halt_mask_o(smask_o), .module_sleep_bit_o(sleep_o), .periph_halt_mask_o(pmask_o),
   .periph_access_ok_o(acc_o), .periph_rst_o(prst_o), .src_en_o(en_o)
);
initial forever #50 sys_clk_i = ~sys_clk_i;
initial forever #20 fclk = ~fclk;
// sample 5 ns into the 20 ns high phase, away from the gate edges
always @(posedge fclk) #5 seen = seen | {pclk_o, gsrc_o};
////////////////////////////////////////////////////////////////////////
task automatic check(input logic [31:0] got, input logic [31:0] exp);
   n_checks++;
   if (got !== exp)
   begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
   end
endtask
task automatic test_done;
   $display("checks %0d mismatches %0d", n_checks, miscompares);
   if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
   else
      $display("Some tests failed");
   $finish;
endtask
task automatic tick(input int n);
   repeat (n) @(posedge sys_clk_i);
   #1;
endtask
task automatic put(input sw_write_type v);
   @(posedge sys_clk_i);
   sw <= v;
   @(posedge sys_clk_i);
   sw <= '0;
   #1;
endtask
task automatic ckey(input logic [31:0] d);
   @(posedge sys_clk_i);
   ckw <= 1'b1;
   ckd <= d;
   @(posedge sys_clk_i);
   ckw <= 1'b0;
   #1;
endtask
task automatic clocks(input chip_mode_type m, input logic [15:0] e);
   @(posedge sys_clk_i);
   mode <= m;
   tick(4);
   seen = '0;
   tick(3);
   check(seen, e);
endtask
function automatic src_en_type exp_en(input chip_mode_type m, input logic [2:0] k, input logic v);
   logic run;
   run = m inside {MODE_RUN, MODE_PERIODIC_WAKE_RUN};
   exp_en = {1'b1, run | k[0], run | k[1], (m != MODE_DEEPEST_HALT) | v,
      (m == MODE_RUN) | (k[2] & (m inside {MODE_STOP, MODE_PERIODIC_HALT})), run, run, run};
endfunction
////////////////////////////////////////////////////////////////////////
initial
begin
   #5000000;
   miscompares++;
   test_done;
end
initial
begin
   repeat (12) @(posedge sys_clk_i);
   srst_i <= 1'b0;
   tick(1);
   check({smask_o, sleep_o, pmask_o, acc_o}, {3'h0, 8'hff, 8'h00, 8'h00});
   $display("test reset_values done");
   put({33'h0, 1'b1, SRC_SEL_PLL, 32'h1, 11'h0});
   ckey(32'ha5a5a500);
   put({33'h0, 1'b1, SRC_SEL_PLL, 32'h1, 11'h0});
   check(smask_o, 3'h0);
   ckey(UNLOCK_KEY);
   foreach (kv[p])
   begin
      for (int i = 0; i < 3; i++)
         put({33'h0, 1'b1, 3'(i), 31'h7fffffff, kv[p][i], 11'h0});
      check(smask_o, kv[p]);
      for (int m = 0; m < 10; m++)
      begin
         @(posedge sys_clk_i);
         mode <= chip_mode_type'(m / 2);
         vmon <= m[0];
         tick(2);
         check(en_o, exp_en(chip_mode_type'(m / 2), kv[p], m[0]));
      end
   end
   $display("test source_modes done");
   put({69'h0, 1'b1, 8'h01, 1'b0, 1'b1});
   check(sleep_o, 8'hff);
   put({1'b1, UNLOCK_KEY, 47'h0});
   put({69'h0, 1'b1, 8'h01, 1'b0, 1'b1});
   put({69'h0, 1'b1, 8'h02, 1'b0, 1'b0});
   check({sleep_o, pmask_o, acc_o}, {8'hfc, 8'h01, 8'h03});
   clocks(MODE_RUN, 16'h03ff);
   clocks(MODE_STOP, 16'h01b0);
   clocks(MODE_DEEPEST_HALT, 16'h01b0);
   clocks(MODE_PERIODIC_WAKE_RUN, 16'h03f7);
   clocks(MODE_RUN, 16'h03ff);
   @(posedge sys_clk_i);
   rel <= 1'b1;
   #1;
   check(prst_o, 8'h03);
   @(posedge sys_clk_i);
   rel <= 1'b0;
   mrst <= 8'h03;
   sw <= {69'h0, 1'b1, 8'h01, 1'b0, 1'b1};
   @(posedge sys_clk_i);
   mrst <= '0;
   sw <= '0;
   tick(1);
   check({sleep_o, acc_o}, {8'hff, 8'h00});
   $display("test module_sleep done");
   test_done;
end
endmodule
